// [hw/gpx_port_block.sv]
// Purpose: three gpio ports, external interrupt groups, misc control
// Assumes: Avalon-MM word addressing, core_clk is the oscillator
// Notes: every access takes one wait cycle
//
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "gpx_params.svh"
module gpx_port_block #(
  parameter gpx_pkg::gpx_byte_t OPT_MASK_A = 8'hff,
  parameter gpx_pkg::gpx_byte_t OPT_MASK_B = 8'hff,
  parameter gpx_pkg::gpx_byte_t OPT_MASK_C = 8'hff,
  parameter gpx_pkg::gpx_byte_t TOD_MASK_A = 8'h50
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire gpx_pkg::gpx_byte_t portAIn,
  output gpx_pkg::gpx_byte_t portAOut,
  output gpx_pkg::gpx_byte_t portAOeN,
  output gpx_pkg::gpx_byte_t portAPullUp,
  input wire gpx_pkg::gpx_byte_t portBIn,
  output gpx_pkg::gpx_byte_t portBOut,
  output gpx_pkg::gpx_byte_t portBOeN,
  output gpx_pkg::gpx_byte_t portBPullUp,
  input wire gpx_pkg::gpx_byte_t portCIn,
  output gpx_pkg::gpx_byte_t portCOut,
  output gpx_pkg::gpx_byte_t portCOeN,
  output gpx_pkg::gpx_byte_t portCPullUp,
  input wire logic cpuIntMask,
  input wire logic irqSourceOption,
  input wire logic vecFetchZero,
  input wire logic vecFetchOne,
  output logic extIrqGroupZero,
  output logic extIrqGroupOne,
  output logic wakeUp,
  output logic cpuClkOut,
  output logic spiSelectLevel,
  output logic spiMasterOutDisable,
  output logic spiSlaveOutDisable
);
  import gpx_pkg::*;

  // half period of the cpu clock in oscillator cycles
  function automatic logic [4:0] halfOf(input logic slow, input logic [1:0] sel);
    logic [4:0] h;
    h = `GPX_HALF_NORM;
    if (slow)
    begin
      unique case (sel)
        2'b00: h = `GPX_HALF_D4;
        2'b10: h = `GPX_HALF_D8;
        2'b01: h = `GPX_HALF_D16;
        2'b11: h = `GPX_HALF_D32;
      endcase
    end
    return h;
  endfunction

  // register index match
  function automatic logic hit(input logic [5:0] a, input logic [5:0] idx);
    return a == idx;
  endfunction

  logic waitReq_r, cpuClk_r, selLvl_r, wake_r;
  logic [31:0] rdData_r;
  logic [4:0] divCnt_r;
  gpx_byte_t misc1_r, misc2_r, misc1Nxt;
  gpx_byte_t dA, dB, dC, rA, rB, rC, oA, oB, oC;
  gpx_byte_t rdA, rdB, rdC, enA, enB, enC, pinA, pinB, pinC;
  gpx_byte_t altEnC, altValC, rdMux, wByte;
  logic req, takeRq, wrStb, sense0Wr, sense1Wr;
  logic enC0, enC1, grp0, grp1, irq0, irq1;
  logic [4:0] half, halfM1;

  // bus handshake: one wait cycle, then the answer edge
  assign req = avs_read | avs_write;
  assign takeRq = req & waitReq_r;
  assign wrStb = avs_write & ~waitReq_r;
  assign wByte = avs_writedata[7:0];
  assign avs_waitrequest = waitReq_r;
  assign avs_readdata = rdData_r;

  // read selection; unmapped indices read zero
  assign rdMux = hit(avs_address, `GPX_IDX_A_DATA) ? rdA :
                 hit(avs_address, `GPX_IDX_A_DIR) ? rA :
                 hit(avs_address, `GPX_IDX_A_OPT) ? oA :
                 hit(avs_address, `GPX_IDX_B_DATA) ? rdB :
                 hit(avs_address, `GPX_IDX_B_DIR) ? rB :
                 hit(avs_address, `GPX_IDX_B_OPT) ? oB :
                 hit(avs_address, `GPX_IDX_C_DATA) ? rdC :
                 hit(avs_address, `GPX_IDX_C_DIR) ? rC :
                 hit(avs_address, `GPX_IDX_C_OPT) ? oC :
                 hit(avs_address, `GPX_IDX_MISC1) ? misc1_r :
                 hit(avs_address, `GPX_IDX_MISC2) ? misc2_r : 8'h00;

  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      waitReq_r <= 1'b1;
      rdData_r <= 32'h0000_0000;
    end
    else
    begin
      waitReq_r <= ~takeRq;
      if (takeRq & avs_read) rdData_r <= {24'h00_0000, rdMux};
    end

  // misc one: sense fields only accepted while the cpu mask is set
  assign misc1Nxt = cpuIntMask ? wByte :
                    {misc1_r[7:6], wByte[5], misc1_r[4:3], wByte[2:0]};
  assign sense0Wr = wrStb & hit(avs_address, `GPX_IDX_MISC1) & cpuIntMask &
                    (wByte[`GPX_F_SENSE0] != misc1_r[`GPX_F_SENSE0]);
  assign sense1Wr = wrStb & hit(avs_address, `GPX_IDX_MISC1) & cpuIntMask &
                    (wByte[`GPX_F_SENSE1] != misc1_r[`GPX_F_SENSE1]);

  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      misc1_r <= `GPX_REG_RST;
      misc2_r <= `GPX_REG_RST;
    end
    else
    begin
      if (wrStb & hit(avs_address, `GPX_IDX_MISC1)) misc1_r <= misc1Nxt;
      if (wrStb & hit(avs_address, `GPX_IDX_MISC2)) misc2_r <= wByte & `GPX_MISC2_MASK;
    end

  // clock out on port C alternate function
  assign altEnC = {5'b00000, misc1_r[`GPX_F_CLKOUT], 2'b00};
  assign altValC = {5'b00000, cpuClk_r, 2'b00};

  gpx_pin_port #(
    .OPT_MASK(OPT_MASK_A),
    .TOD_MASK(TOD_MASK_A)
  ) u_portA (
    .core_clk(core_clk),
    .rst(rst),
    .wrData(wrStb & hit(avs_address, `GPX_IDX_A_DATA)),
    .wrDir(wrStb & hit(avs_address, `GPX_IDX_A_DIR)),
    .wrOpt(wrStb & hit(avs_address, `GPX_IDX_A_OPT)),
    .wdata(wByte),
    .altEn(8'h00),
    .altVal(8'h00),
    .padIn(portAIn),
    .padOut(portAOut),
    .padOeN(portAOeN),
    .pullUpEn(portAPullUp),
    .dirQ(rA),
    .optQ(oA),
    .dataQ(dA),
    .readVal(rdA),
    .irqEn(enA),
    .pinLevel(pinA)
  );

  gpx_pin_port #(
    .OPT_MASK(OPT_MASK_B),
    .TOD_MASK(8'h00)
  ) u_portB (
    .core_clk(core_clk),
    .rst(rst),
    .wrData(wrStb & hit(avs_address, `GPX_IDX_B_DATA)),
    .wrDir(wrStb & hit(avs_address, `GPX_IDX_B_DIR)),
    .wrOpt(wrStb & hit(avs_address, `GPX_IDX_B_OPT)),
    .wdata(wByte),
    .altEn(8'h00),
    .altVal(8'h00),
    .padIn(portBIn),
    .padOut(portBOut),
    .padOeN(portBOeN),
    .pullUpEn(portBPullUp),
    .dirQ(rB),
    .optQ(oB),
    .dataQ(dB),
    .readVal(rdB),
    .irqEn(enB),
    .pinLevel(pinB)
  );

  gpx_pin_port #(
    .OPT_MASK(OPT_MASK_C),
    .TOD_MASK(8'h00)
  ) u_portC (
    .core_clk(core_clk),
    .rst(rst),
    .wrData(wrStb & hit(avs_address, `GPX_IDX_C_DATA)),
    .wrDir(wrStb & hit(avs_address, `GPX_IDX_C_DIR)),
    .wrOpt(wrStb & hit(avs_address, `GPX_IDX_C_OPT)),
    .wdata(wByte),
    .altEn(altEnC),
    .altVal(altValC),
    .padIn(portCIn),
    .padOut(portCOut),
    .padOeN(portCOeN),
    .pullUpEn(portCPullUp),
    .dirQ(rC),
    .optQ(oC),
    .dataQ(dC),
    .readVal(rdC),
    .irqEn(enC),
    .pinLevel(pinC)
  );

  // group routing and wired and of enabled pins
  assign enC0 = ~irqSourceOption;
  assign enC1 = irqSourceOption;
  assign grp0 = (&(pinA | ~enA)) & (&(pinC | ~(enC & {8{enC0}})));
  assign grp1 = (&(pinB | ~enB)) & (&(pinC | ~(enC & {8{enC1}})));

  gpx_irq_sense u_irq0 (
    .core_clk(core_clk),
    .rst(rst),
    .grpLevel(grp0),
    .sense(gpx_sense_t'(misc1_r[`GPX_F_SENSE0])),
    .senseWr(sense0Wr),
    .vecFetch(vecFetchZero),
    .intMask(cpuIntMask),
    .irqReq(irq0),
    .pending()
  );

  gpx_irq_sense u_irq1 (
    .core_clk(core_clk),
    .rst(rst),
    .grpLevel(grp1),
    .sense(gpx_sense_t'(misc1_r[`GPX_F_SENSE1])),
    .senseWr(sense1Wr),
    .vecFetch(vecFetchOne),
    .intMask(cpuIntMask),
    .irqReq(irq1),
    .pending()
  );
  assign extIrqGroupZero = irq0;
  assign extIrqGroupOne = irq1;

  // cpu clock divider from the oscillator
  assign half = halfOf(misc1_r[`GPX_F_SLOW], misc1_r[`GPX_F_DIVSEL]);
  assign halfM1 = half - 5'd1;

  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      divCnt_r <= 5'd0;
      cpuClk_r <= 1'b0;
    end
    else if (divCnt_r >= halfM1)
    begin
      divCnt_r <= 5'd0;
      cpuClk_r <= ~cpuClk_r;
    end
    else
    begin
      divCnt_r <= divCnt_r + 5'd1;
    end
  assign cpuClkOut = cpuClk_r;

  // spi select source, wake request
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      selLvl_r <= 1'b0;
      wake_r <= 1'b0;
    end
    else
    begin
      selLvl_r <= misc2_r[`GPX_F_SSM] ? misc2_r[`GPX_F_SSI] : pinB[`GPX_SPI_SEL_BIT];
      wake_r <= irq0 | irq1;
    end
  assign spiSelectLevel = selLvl_r;
  assign spiMasterOutDisable = misc2_r[`GPX_F_MODIS];
  assign spiSlaveOutDisable = misc2_r[`GPX_F_SODIS];
  assign wakeUp = wake_r;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence sDivSteady;
    $stable(misc1_r) ##1 ($changed(cpuClk_r) && $stable(misc1_r));
  endsequence
  busAnswer_a: assert property (takeRq |=> !waitReq_r ##1 waitReq_r)
    else $error("bus answer not after one wait cycle");
  dataWrite_a: assert property ((wrStb && hit(avs_address, `GPX_IDX_A_DATA)) |=> dA == $past(wByte))
    else $error("data latch not loaded");
  readBack_a: assert property ((takeRq && avs_read && hit(avs_address, `GPX_IDX_A_DATA))
    |=> avs_readdata[7:0] == $past(rdA))
    else $error("data read does not follow direction");
  senseLock_a: assert property ((wrStb && hit(avs_address, `GPX_IDX_MISC1) && !cpuIntMask)
    |=> $stable(misc1_r[7:6]) && $stable(misc1_r[4:3]))
    else $error("sense field changed while unmasked");
  clkPin_a: assert property ((misc1_r[5] && $stable(misc1_r[5]))
    |=> portCOut[2] == $past(cpuClk_r) && !portCOeN[2])
    else $error("clock out pin not driven with cpu clock");
  divPeriod_a: assert property (sDivSteady |-> $past(divCnt_r) == $past(halfM1))
    else $error("cpu clock half period wrong");
  selSrc_a: assert property (misc2_r[1] |=> spiSelectLevel == $past(misc2_r[0]))
    else $error("select level not from internal bit");
  wake_a: assert property ((irq0 || irq1) |=> wakeUp)
    else $error("enabled interrupt did not wake");

  // register loads seen from the port side
  dataWriteB_a: assert property ((wrStb && hit(avs_address, `GPX_IDX_B_DATA)) |=> dB == $past(wByte))
    else $error("port b data latch not loaded");
  dataWriteC_a: assert property ((wrStb && hit(avs_address, `GPX_IDX_C_DATA)) |=> dC == $past(wByte))
    else $error("port c data latch not loaded");
  dirWriteA_a: assert property ((wrStb && hit(avs_address, `GPX_IDX_A_DIR)) |=> rA == $past(wByte))
    else $error("port a direction not loaded");
  dirWriteC_a: assert property ((wrStb && hit(avs_address, `GPX_IDX_C_DIR)) |=> rC == $past(wByte))
    else $error("port c direction not loaded");
  optWriteA_a: assert property ((wrStb && hit(avs_address, `GPX_IDX_A_OPT))
    |=> oA == ($past(wByte) & OPT_MASK_A))
    else $error("port a option not loaded");
  optWriteB_a: assert property ((wrStb && hit(avs_address, `GPX_IDX_B_OPT))
    |=> oB == ($past(wByte) & OPT_MASK_B))
    else $error("port b option not loaded");

  // misc registers: masked writes take every field, unmasked ones keep the sense fields
  miscMasked_a: assert property ((wrStb && hit(avs_address, `GPX_IDX_MISC1) && cpuIntMask)
    |=> misc1_r == $past(wByte))
    else $error("misc one write lost while masked");
  miscFree_a: assert property ((wrStb && hit(avs_address, `GPX_IDX_MISC1) && !cpuIntMask)
    |=> misc1_r[5] == $past(wByte[5]) && misc1_r[2:0] == $past(wByte[2:0]))
    else $error("clock fields not written while unmasked");
  miscTwo_a: assert property ((wrStb && hit(avs_address, `GPX_IDX_MISC2))
    |=> spiMasterOutDisable == $past(wByte[3]) && spiSlaveOutDisable == $past(wByte[2]))
    else $error("spi output disables not written");

  // a low enabled pin pulls its whole group low; port c joins the group picked by the option
  grpZeroLow_a: assert property ((|(enA & ~pinA)) || (!irqSourceOption && |(enC & ~pinC))
    |-> !grp0)
    else $error("low enabled pin did not pull group zero");
  grpOneLow_a: assert property ((|(enB & ~pinB)) || (irqSourceOption && |(enC & ~pinC))
    |-> !grp1)
    else $error("low enabled pin did not pull group one");

  // pad, wake and bus idle behaviour
  todPull_a: assert property (!(|(portAPullUp & TOD_MASK_A)))
    else $error("pull-up on a true open-drain pin");
  wakeIdle_a: assert property (!(irq0 || irq1) |=> !wakeUp)
    else $error("wake raised with no interrupt");
  busIdle_a: assert property (!req |=> waitReq_r)
    else $error("bus answered with no request");
  readHole_a: assert property ((takeRq && avs_read && avs_address > `GPX_IDX_MISC2)
    |=> avs_readdata == 32'h0000_0000)
    else $error("unmapped index did not read zero");
endmodule

// [hw/gpx_params.svh]
// Purpose: offsets, field positions, reset values and divider counts
// Assumes: register index on the bus is the word address
// Notes:
`ifndef GPX_PARAMS_SVH
`define GPX_PARAMS_SVH
`define GPX_IDX_C_DATA 6'h00
`define GPX_IDX_C_DIR 6'h01
`define GPX_IDX_C_OPT 6'h02
`define GPX_IDX_B_DATA 6'h04
`define GPX_IDX_B_DIR 6'h05
`define GPX_IDX_B_OPT 6'h06
`define GPX_IDX_A_DATA 6'h08
`define GPX_IDX_A_DIR 6'h09
`define GPX_IDX_A_OPT 6'h0a
`define GPX_IDX_MISC1 6'h10
`define GPX_IDX_MISC2 6'h11
`define GPX_REG_RST 8'h00
`define GPX_MISC2_MASK 8'h0f
`define GPX_F_SENSE1 7:6
`define GPX_F_CLKOUT 5
`define GPX_F_SENSE0 4:3
`define GPX_F_DIVSEL 2:1
`define GPX_F_SLOW 0
`define GPX_F_MODIS 3
`define GPX_F_SODIS 2
`define GPX_F_SSM 1
`define GPX_F_SSI 0
`define GPX_CLKOUT_BIT 2
`define GPX_SPI_SEL_BIT 7
`define GPX_HALF_NORM 5'd1
`define GPX_HALF_D4 5'd2
`define GPX_HALF_D8 5'd4
`define GPX_HALF_D16 5'd8
`define GPX_HALF_D32 5'd16
`endif

// [hw/gpx_pkg.sv]
// Purpose: shared types of the port block
// Assumes: nothing
// Notes: sense coding matches the misc register fields
package gpx_pkg;
  typedef logic [7:0] gpx_byte_t;
  typedef enum logic [1:0] {
    GPX_FALL_LOW = 2'b00,
    GPX_RISE = 2'b01,
    GPX_FALL = 2'b10,
    GPX_BOTH = 2'b11
  } gpx_sense_t;
endpackage

// [hw/gpx_pin_port.sv]
// Purpose: one 8-bit port: registers, pin synchroniser, pad drive
// Assumes: pad wire resolved outside; oe low means driving
// Notes: alternate function overrides the pad drive and pull-up settings
`timescale 1ns/1ps
`include "gpx_params.svh"
module gpx_pin_port #(
  parameter gpx_pkg::gpx_byte_t OPT_MASK = 8'hff,
  parameter gpx_pkg::gpx_byte_t TOD_MASK = 8'h00
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic wrData,
  input wire logic wrDir,
  input wire logic wrOpt,
  input wire gpx_pkg::gpx_byte_t wdata,
  input wire gpx_pkg::gpx_byte_t altEn,
  input wire gpx_pkg::gpx_byte_t altVal,
  input wire gpx_pkg::gpx_byte_t padIn,
  output gpx_pkg::gpx_byte_t padOut,
  output gpx_pkg::gpx_byte_t padOeN,
  output gpx_pkg::gpx_byte_t pullUpEn,
  output gpx_pkg::gpx_byte_t dirQ,
  output gpx_pkg::gpx_byte_t optQ,
  output gpx_pkg::gpx_byte_t dataQ,
  output gpx_pkg::gpx_byte_t readVal,
  output gpx_pkg::gpx_byte_t irqEn,
  output gpx_pkg::gpx_byte_t pinLevel
);
  import gpx_pkg::*;
  gpx_byte_t data_r, dir_r, opt_r, s1_r, s2_r, s3_r, pin_r;
  gpx_byte_t padOut_r, padOeN_r, pullUp_r;
  gpx_byte_t optEff, drvLow, drvHigh, odHi;

  // a true open-drain pin without an option bit cannot be served
  if ((TOD_MASK & ~OPT_MASK) != 8'h00)
  begin : g_chk
    $error("gpx_pin_port: open-drain pins need an option bit");
  end

  // option and direction decode
  assign optEff = opt_r & OPT_MASK;
  assign readVal = (dir_r & data_r) | (~dir_r & pin_r);
  assign irqEn = ~dir_r & optEff;
  assign drvLow = (altEn & ~altVal) | (~altEn & dir_r & ~data_r);
  assign drvHigh = (altEn & altVal) | (~altEn & dir_r & data_r & optEff & ~TOD_MASK);
  assign odHi = ~altEn & dir_r & data_r & ~optEff;
  assign dataQ = data_r;
  assign dirQ = dir_r;
  assign optQ = optEff;
  assign pinLevel = pin_r;
  assign padOut = padOut_r;
  assign padOeN = padOeN_r;
  assign pullUpEn = pullUp_r;

  // software registers
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      data_r <= `GPX_REG_RST;
      dir_r <= `GPX_REG_RST;
      opt_r <= `GPX_REG_RST;
    end
    else
    begin
      if (wrData) data_r <= wdata;
      if (wrDir) dir_r <= wdata;
      if (wrOpt) opt_r <= wdata;
    end

  // three-stage sync; a level counts once stages two and three agree
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      s1_r <= 8'h00;
      s2_r <= 8'h00;
      s3_r <= 8'h00;
      pin_r <= 8'h00;
    end
    else
    begin
      s1_r <= padIn;
      s2_r <= s1_r;
      s3_r <= s2_r;
      pin_r <= (s2_r & s3_r) | (pin_r & (s2_r ^ s3_r));
    end

  // registered pad drive and pull-up
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      padOut_r <= 8'h00;
      padOeN_r <= 8'hff;
      pullUp_r <= 8'h00;
    end
    else
    begin
      padOut_r <= drvHigh;
      padOeN_r <= ~(drvLow | drvHigh);
      pullUp_r <= ~dir_r & optEff & ~TOD_MASK & ~altEn;
    end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  odRelease_a: assert property ((|odHi) |=> &(padOeN_r | ~$past(odHi)))
    else $error("open-drain high pin is being driven");
endmodule

// [hw/gpx_irq_sense.sv]
// Purpose: sensitivity decode and request latch of one interrupt group
// Assumes: group level is already synchronised
// Notes: a new event beats a fetch or a sense change in the same cycle
`timescale 1ns/1ps
module gpx_irq_sense (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic grpLevel,
  input wire gpx_pkg::gpx_sense_t sense,
  input wire logic senseWr,
  input wire logic vecFetch,
  input wire logic intMask,
  output logic irqReq,
  output logic pending
);
  import gpx_pkg::*;
  logic prev_r, pend_r, req_r;
  logic rise, fall, evt, pendNxt;

  // edge and level events
  assign rise = grpLevel & ~prev_r;
  assign fall = ~grpLevel & prev_r;
  always_comb
  begin
    unique case (sense)
      GPX_FALL_LOW: evt = fall | ~grpLevel;
      GPX_RISE: evt = rise;
      GPX_FALL: evt = fall;
      GPX_BOTH: evt = rise | fall;
    endcase
  end
  assign pendNxt = evt | (pend_r & ~vecFetch & ~senseWr);
  assign irqReq = req_r;
  assign pending = pend_r;

  // latch and masked request
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      prev_r <= 1'b1;
      pend_r <= 1'b0;
      req_r <= 1'b0;
    end
    else
    begin
      prev_r <= grpLevel;
      pend_r <= pendNxt;
      req_r <= pendNxt & ~intMask;
    end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  fetchClear_a: assert property ((vecFetch && !evt) |=> !pend_r)
    else $error("request latch kept after vector fetch");
  maskGate_a: assert property (irqReq |-> !$past(intMask))
    else $error("request raised while cpu mask set");
endmodule

// [verif/gpx_pin_model.sv]
// Purpose: board side of one 8-bit port, resolving each pad wire
// Assumes: oe low means the block drives the pad
// Notes: an undriven pin without pull-up shows a pattern that flips every cycle
`timescale 1ns/1ps
module gpx_pin_model (
  input wire logic core_clk,
  input wire gpx_pkg::gpx_byte_t padOut,
  input wire gpx_pkg::gpx_byte_t padOeN,
  input wire gpx_pkg::gpx_byte_t pullUp,
  input wire gpx_pkg::gpx_byte_t extVal,
  input wire gpx_pkg::gpx_byte_t extEn,
  output gpx_pkg::gpx_byte_t padIn
);
  import gpx_pkg::*;
  gpx_byte_t floatPat_r = 8'h5a;
  // floating level changes each cycle so it is never mistaken for a valid value
  always_ff @(posedge core_clk)
  begin
    floatPat_r <= ~floatPat_r;
  end
  // wire level: block drive, then board drive, then pull-up, else floating
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (!padOeN[i])
        padIn[i] = padOut[i];
      else if (extEn[i])
        padIn[i] = extVal[i];
      else if (pullUp[i])
        padIn[i] = 1'b1;
      else
        padIn[i] = floatPat_r[i];
    end
  end
endmodule

// [verif/gpx_port_block_tb_top.sv]
// Purpose: self-checking bench of the port block over Avalon-MM
// Assumes: one wait cycle per access, 4-edge pin synchroniser
// Notes: random port setups plus hand-written interrupt and clock cases
`timescale 1ns/1ps
module gpx_port_block_tb_top;
  import gpx_pkg::*;
  localparam gpx_byte_t TOD_A = 8'h50;
  logic core_clk, rst, avs_read, avs_write, cpuIntMask, irqSourceOption, vecFetchZero, vecFetchOne;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic avs_waitrequest, extIrqGroupZero, extIrqGroupOne, wakeUp, cpuClkOut, spiSel, spiMod, spiSod;
  gpx_byte_t padIn [3], padOut [3], padOeN [3], pullUp [3], extVal [3], extEn [3];
  int miscompares, cmp_count;
  gpx_byte_t divCodes [5] = '{8'h00, 8'h01, 8'h05, 8'h03, 8'h07};
  gpx_port_block #(.TOD_MASK_A(TOD_A)) dut (
    .core_clk(core_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .portAIn(padIn[0]), .portAOut(padOut[0]), .portAOeN(padOeN[0]), .portAPullUp(pullUp[0]),
    .portBIn(padIn[1]), .portBOut(padOut[1]), .portBOeN(padOeN[1]), .portBPullUp(pullUp[1]),
    .portCIn(padIn[2]), .portCOut(padOut[2]), .portCOeN(padOeN[2]), .portCPullUp(pullUp[2]),
    .cpuIntMask(cpuIntMask), .irqSourceOption(irqSourceOption), .vecFetchZero(vecFetchZero),
    .vecFetchOne(vecFetchOne), .extIrqGroupZero(extIrqGroupZero), .extIrqGroupOne(extIrqGroupOne),
    .wakeUp(wakeUp), .cpuClkOut(cpuClkOut), .spiSelectLevel(spiSel), .spiMasterOutDisable(spiMod),
    .spiSlaveOutDisable(spiSod));
  // board models for ports a, b, c
  for (genvar k = 0; k < 3; k++)
  begin : g_pin
    gpx_pin_model pm (.core_clk(core_clk), .padOut(padOut[k]), .padOeN(padOeN[k]), .pullUp(pullUp[k]),
      .extVal(extVal[k]), .extEn(extEn[k]), .padIn(padIn[k]));
  end
  // clock source
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  function automatic gpx_byte_t exp_oen(gpx_byte_t dv, gpx_byte_t ov, gpx_byte_t d, gpx_byte_t t);
    return ~(dv & ((ov & ~t) | ~d));
  endfunction
  function automatic gpx_byte_t exp_pu(gpx_byte_t dv, gpx_byte_t ov, gpx_byte_t t);
    return ~dv & ov & ~t;
  endfunction
  function automatic int exp_div(gpx_byte_t m);
    if (!m[0])
      return 2;
    case ({m[2], m[1]})
      2'b00: return 4;
      2'b10: return 8;
      2'b01: return 16;
      default: return 32;
    endcase
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // one Avalon transfer, held until waitrequest is seen low at an edge
  task automatic bus(input logic rd, input logic [5:0] a, input gpx_byte_t d, output logic [31:0] q);
    int n;
    @(posedge core_clk);
    avs_address <= a;
    avs_read <= rd;
    avs_write <= !rd;
    avs_writedata <= {24'h000000, d};
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50)
      chk(32'h0, 32'h1, "bus timeout");
  endtask
  task automatic wr(input logic [5:0] a, input gpx_byte_t d);
    logic [31:0] q;
    bus(1'b0, a, d, q);
  endtask
  task automatic rdc(input logic [5:0] a, input gpx_byte_t e);
    logic [31:0] q;
    bus(1'b1, a, 8'h00, q);
    chk(q, {24'h000000, e}, "register read");
  endtask
  task automatic set_pin(input logic g, input logic v);
    if (g)
      extVal[2][0] <= v;
    else
      extVal[0][0] <= v;
  endtask
  task automatic fetch(input logic g);
    @(posedge core_clk);
    if (g) vecFetchOne <= 1'b1; else vecFetchZero <= 1'b1;
    @(posedge core_clk);
    vecFetchOne <= 1'b0;
    vecFetchZero <= 1'b0;
  endtask
  // sensitivity walk: fall, fetch, masked rise, unmask, final clear
  task automatic irq_case(input logic g, input logic [1:0] code);
    set_pin(g, 1'b1);
    cyc(8);
    wr(6'h10, g ? {code, 6'h00} : {3'h0, code, 3'h0});
    // drop requests left pending by earlier port setups
    fetch(1'b0);
    fetch(1'b1);
    cpuIntMask <= 1'b0;
    cyc(8);
    chk(g ? extIrqGroupOne : extIrqGroupZero, 0, "idle irq");
    set_pin(g, 1'b0);
    cyc(8);
    chk(g ? extIrqGroupOne : extIrqGroupZero, code != 2'b01, "fall irq");
    chk(wakeUp, code != 2'b01, "wake");
    fetch(g);
    cyc(3);
    chk(g ? extIrqGroupOne : extIrqGroupZero, code == 2'b00, "after fetch");
    cpuIntMask <= 1'b1;
    set_pin(g, 1'b1);
    cyc(8);
    chk(g ? extIrqGroupOne : extIrqGroupZero, 0, "masked irq");
    cpuIntMask <= 1'b0;
    cyc(3);
    chk(g ? extIrqGroupOne : extIrqGroupZero, code[0] | (code == 2'b00), "rise irq");
    fetch(g);
    cyc(3);
    chk(g ? extIrqGroupOne : extIrqGroupZero, 0, "cleared");
    cpuIntMask <= 1'b1;
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // watchdog
  initial
  begin
    #1000000;
    miscompares++;
    $display("[ERR] %0t run did not finish", $time);
    end_sim;
  end
  // main sequence
  initial
  begin
    gpx_byte_t dv, ov, d, ev, ee, pu;
    int p;
    rst <= 1'b1; avs_read <= 1'b0; avs_write <= 1'b0; avs_address <= 6'h00; avs_writedata <= 32'h0;
    cpuIntMask <= 1'b1; irqSourceOption <= 1'b0; vecFetchZero <= 1'b0; vecFetchOne <= 1'b0;
    miscompares = 0;
    cmp_count = 0;
    for (int k = 0; k < 3; k++)
    begin
      extVal[k] <= 8'hff;
      extEn[k] <= 8'hff;
    end
    void'($urandom(32'h147ca429));
    cyc(16);
    rst <= 1'b0;
    cyc(4);
    // data indices of input pins read the board level, which is driven high
    for (int i = 0; i < 18; i++)
      rdc(i[5:0], (i == 0 || i == 4 || i == 8) ? 8'hff : 8'h00);
    wr(6'h03, 8'hff);
    rdc(6'h03, 8'h00);
    $display("test reset values done");
    repeat (20)
    begin
      for (int k = 0; k < 3; k++)
      begin
        d = $urandom; dv = $urandom; ov = $urandom; ev = $urandom;
        pu = exp_pu(dv, ov, k == 0 ? TOD_A : 8'h00);
        ee = $urandom;
        ee = ee | ~pu;
        wr(6'h08 - 6'(4 * k), d);
        wr(6'h09 - 6'(4 * k), dv);
        wr(6'h0a - 6'(4 * k), ov);
        extVal[k] <= ev;
        extEn[k] <= ee;
        cyc(6);
        rdc(6'h08 - 6'(4 * k), (dv & d) | (~dv & ((ee & ev) | ~ee)));
        chk(padOeN[k], exp_oen(dv, ov, d, k == 0 ? TOD_A : 8'h00), "oe");
        chk(pullUp[k], pu, "pull-up");
        chk(padOut[k] & ~padOeN[k], d & ~padOeN[k], "pad level");
      end
    end
    $display("test random ports done");
    cpuIntMask <= 1'b0;
    wr(6'h10, 8'hff);
    rdc(6'h10, 8'h27);
    cpuIntMask <= 1'b1;
    wr(6'h10, 8'hd8);
    rdc(6'h10, 8'hd8);
    wr(6'h11, 8'hff);
    rdc(6'h11, 8'h0f);
    cyc(2);
    chk({spiMod, spiSod, spiSel}, 3'b111, "spi controls");
    wr(6'h11, 8'h02);
    cyc(2);
    chk({spiMod, spiSod, spiSel}, 3'b000, "internal select");
    wr(6'h05, 8'h00);
    extEn[1] <= 8'hff;
    extVal[1] <= 8'h80;
    wr(6'h11, 8'h00);
    cyc(6);
    chk(spiSel, 1'b1, "pin select");
    $display("test misc done");
    foreach (divCodes[i])
    begin
      wr(6'h10, divCodes[i] | 8'h20);
      for (int r = 0; r < 3; r++)
      begin
        p = 0;
        do
        begin
          dv[0] = cpuClkOut;
          @(posedge core_clk);
          p++;
        end
        while (!(dv[0] === 1'b0 && cpuClkOut === 1'b1) && p < 100);
      end
      chk(p, exp_div(divCodes[i]), "clock period");
      chk(padOeN[2][2], 1'b0, "clock out drive");
    end
    $display("test clock done");
    wr(6'h05, 8'h00);
    wr(6'h06, 8'h00);
    for (int g = 0; g < 2; g++)
    begin
      irqSourceOption <= g[0];
      wr(6'h09, 8'h00);
      wr(6'h0a, g ? 8'h00 : 8'h01);
      wr(6'h01, 8'h00);
      wr(6'h02, g ? 8'h01 : 8'h00);
      extVal[0] <= 8'hff;
      extVal[2] <= 8'hff;
      extEn[0] <= 8'hff;
      extEn[2] <= 8'hff;
      for (int c = 0; c < 4; c++)
        irq_case(g[0], c[1:0]);
    end
    irqSourceOption <= 1'b0;
    wr(6'h02, 8'h00);
    wr(6'h0a, 8'h03);
    extVal[0] <= 8'hfd;
    cyc(8);
    wr(6'h10, 8'h10);
    fetch(1'b0);
    cpuIntMask <= 1'b0;
    set_pin(1'b0, 1'b0);
    cyc(8);
    chk(extIrqGroupZero, 1'b0, "low pin masks group");
    $display("test interrupts done");
    end_sim;
  end
endmodule
